// ### hdl/bscan_pkg.sv
// Purpose: shared constants and types for the boundary-scan test logic
// Assumes: one system clock samples every test-port pin
// Notes: command codes live in the low four bits of the instruction
package bscan_pkg;
    localparam int IR_WIDTH = 13;
    localparam int CMD_WIDTH = 4;
    localparam int ID_WIDTH = 32;
    localparam int TLR_TMS_EDGES = 5;
    localparam int BIST_CORE_CYCLES = 219;
    localparam int PIN_GROUPS_DEFAULT = 4;
    localparam int PINS_PER_GROUP_DEFAULT = 4;
    // Arbitrary identification value, bit 0 set as the scan standard asks
    localparam logic [31:0] ID_CODE_DEFAULT = 32'h0A5C_3001;

    localparam logic [3:0] EXTEST_INSTR = 4'h0;
    localparam logic [3:0] SAMPLE_INSTR = 4'h1;
    localparam logic [3:0] IDCODE_INSTR = 4'h2;
    localparam logic [3:0] RUNBIST_INSTR = 4'h7;
    localparam logic [3:0] FLOAT_ALL_OUTPUTS_INSTR = 4'hB;
    localparam logic [3:0] BYPASS_INSTR = 4'hF;
    localparam logic [12:0] IR_CAPTURE_VALUE = 13'h0001;
    localparam logic [12:0] IR_RESET_VALUE = 13'h0002;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_b;
    } tap_pins_type;
    localparam tap_pins_type PINS_RESET = 4'h7;

    typedef enum logic [3:0] {
        TLR = 4'b0000, RTI = 4'b0001, SEL_DR = 4'b0010, CAP_DR = 4'b0011,
        SH_DR = 4'b0100, EX1_DR = 4'b0101, PA_DR = 4'b0110, EX2_DR = 4'b0111,
        UPD_DR = 4'b1000, SEL_IR = 4'b1001, CAP_IR = 4'b1010, SH_IR = 4'b1011,
        EX1_IR = 4'b1100, PA_IR = 4'b1101, EX2_IR = 4'b1110, UPD_IR = 4'b1111
    } tap_state_type;
endpackage

// ### hdl/boundary_scan_tap.sv
// Purpose: boundary-scan test logic behind a serial test access port
// Assumes: tck, tms, tdi, trst_b are asynchronous pins oversampled by clk
// Notes: clk doubles as the core clock that times the self test
// Function
// R1 - Reset state on power-up, trst, five TMS-high
// R2 - One cell per pin plus controls, serial
// R3 - Control cell one floats its group, zero drives
// R4 - Thirteen-bit instruction, low four bits decode
// R5 - Decode 0000 extest, 0001 sample, 0010 idcode
// R6 - Tester shifts instructions least significant first
// R7 - Idcode and bypass leave core running undisturbed
// R8 - Processor reset leaves test instructions unaffected
// R9 - Extest drives latched cells, captures pin levels
// R10 - System resets processor after extest use
// R11 - Sample captures pin values on rising TCK
// R12 - Update-DR latches shifted data on falling TCK
// R13 - Idcode connects identification register to TDO
// R14 - Self-test selects result bit, presets one, arms
// R15 - Self test starts first rise in idle
// R16 - Result after 219 core cycles, zero passes
// R17 - System keeps core clock, resets after test
// R18 - Float instruction releases all pins until changed
// R19 - Float change takes effect after Update-IR
// R20 - Processor reset never clears test port logic
// R21 - Bypass places one-bit register in path
// R22 - Codes 1101 and 1110 act as bypass
// R23 - Update-IR latches instruction on falling TCK
// R24 - Capture-IR loads fixed value on rising TCK
// R25 - Private codes behave as bypass
`timescale 1ns/1ps
module boundary_scan_tap #(
    parameter int PIN_GROUPS = bscan_pkg::PIN_GROUPS_DEFAULT,
    parameter int PINS_PER_GROUP = bscan_pkg::PINS_PER_GROUP_DEFAULT,
    parameter int BIST_CYCLES = bscan_pkg::BIST_CORE_CYCLES,
    parameter logic [31:0] ID_CODE = bscan_pkg::ID_CODE_DEFAULT
) (
    input wire logic clk, // System and core clock, 100 MHz
    input wire logic rst_b, // Power-up reset, synchronous, low
    input wire logic tck, // Test clock pin
    input wire logic tms, // Test mode select pin
    input wire logic tdi, // Test data in pin
    input wire logic trst_b, // Test reset pin, low
    input wire logic [PIN_GROUPS*PINS_PER_GROUP-1:0] core_out, // Core output values
    input wire logic [PIN_GROUPS-1:0] core_oe, // Core drive enable per group
    input wire logic [PIN_GROUPS*PINS_PER_GROUP-1:0] pin_in, // Pad levels
    input wire logic bist_fail, // Core self-test verdict, high fails
    output logic [PIN_GROUPS*PINS_PER_GROUP-1:0] pin_out, // Pad output values
    output logic [PIN_GROUPS*PINS_PER_GROUP-1:0] pin_oe, // Pad drive enables
    output logic tdo, // Test data out
    output logic tdo_oe, // Test data out enable
    output logic bist_run, // Core self test running
    output logic float_active, // All pins released
    output logic test_reset // Test logic in reset state
);
    localparam int PINS = PIN_GROUPS * PINS_PER_GROUP;
    localparam int CHAIN = PINS + PIN_GROUPS;
    localparam int CW = $clog2(BIST_CYCLES + 1);

    bscan_pkg::tap_pins_type pins_raw, sync1_reg, sync2_reg, sync3_reg;
    bscan_pkg::tap_pins_type level_reg, level_next, agree;
    bscan_pkg::tap_state_type state_reg, state_next;
    logic [bscan_pkg::IR_WIDTH-1:0] ir_shift_reg, ir_reg;
    logic [CHAIN-1:0] chain_reg, upd_reg, chain_capture;
    logic [bscan_pkg::ID_WIDTH-1:0] id_reg;
    logic bypass_reg, result_reg, armed_reg, started_reg, run_reg;
    logic [CW-1:0] cnt_reg;
    logic tdo_reg, tdo_oe_reg, float_reg, test_reset_reg;
    logic [PINS-1:0] pin_out_reg, pin_oe_reg, pin_out_next, pin_oe_next;
    logic tck_rise, tck_fall, tms_now, tdi_now, trst_active;
    logic [3:0] cmd;
    logic sel_ext, sel_sample, sel_id, sel_bist, sel_bypass, sel_bscan;
    logic dr_out, serial_out, shifting;
    logic upd_ir_fall, bist_start, bist_done;

    // Three-stage sync; a change counts once stages two and three agree
    assign pins_raw = {tck, tms, tdi, trst_b};
    assign agree = ~(sync2_reg ^ sync3_reg);
    assign level_next = (sync3_reg & agree) | (level_reg & ~agree);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_reg <= bscan_pkg::PINS_RESET;
            sync2_reg <= bscan_pkg::PINS_RESET;
            sync3_reg <= bscan_pkg::PINS_RESET;
            level_reg <= bscan_pkg::PINS_RESET;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            level_reg <= level_next;
        end
    end

    // Edges of the test clock as seen by clk
    assign tck_rise = level_next.tck & ~level_reg.tck;
    assign tck_fall = ~level_next.tck & level_reg.tck;
    assign tms_now = level_next.tms;
    assign tdi_now = level_next.tdi;
    assign trst_active = ~level_next.trst_b;

    // Controller next state; five TMS-high rises reach reset from anywhere
    always_comb begin
        case (state_reg)
            bscan_pkg::TLR: state_next = tms_now ? bscan_pkg::TLR : bscan_pkg::RTI; // [R1]
            bscan_pkg::RTI: state_next = tms_now ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
            bscan_pkg::SEL_DR: state_next = tms_now ? bscan_pkg::SEL_IR : bscan_pkg::CAP_DR;
            bscan_pkg::CAP_DR: state_next = tms_now ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
            bscan_pkg::SH_DR: state_next = tms_now ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
            bscan_pkg::EX1_DR: state_next = tms_now ? bscan_pkg::UPD_DR : bscan_pkg::PA_DR;
            bscan_pkg::PA_DR: state_next = tms_now ? bscan_pkg::EX2_DR : bscan_pkg::PA_DR;
            bscan_pkg::EX2_DR: state_next = tms_now ? bscan_pkg::UPD_DR : bscan_pkg::SH_DR;
            bscan_pkg::SEL_IR: state_next = tms_now ? bscan_pkg::TLR : bscan_pkg::CAP_IR;
            bscan_pkg::CAP_IR: state_next = tms_now ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
            bscan_pkg::SH_IR: state_next = tms_now ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
            bscan_pkg::EX1_IR: state_next = tms_now ? bscan_pkg::UPD_IR : bscan_pkg::PA_IR;
            bscan_pkg::PA_IR: state_next = tms_now ? bscan_pkg::EX2_IR : bscan_pkg::PA_IR;
            bscan_pkg::EX2_IR: state_next = tms_now ? bscan_pkg::UPD_IR : bscan_pkg::SH_IR;
            bscan_pkg::UPD_DR, bscan_pkg::UPD_IR:
                state_next = tms_now ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
            default: state_next = bscan_pkg::TLR;
        endcase
    end

    // Only power-up and trst reach this; processor reset has no path in
    always_ff @(posedge clk) begin
        if (!rst_b || trst_active) begin
            state_reg <= bscan_pkg::TLR; // [R1] [R20] [R8]
        end else if (tck_rise) begin
            state_reg <= state_next;
        end
    end

    // Instruction shift path and current instruction
    assign upd_ir_fall = tck_fall && state_reg == bscan_pkg::UPD_IR;
    always_ff @(posedge clk) begin
        if (!rst_b || trst_active || state_reg == bscan_pkg::TLR) begin
            ir_shift_reg <= bscan_pkg::IR_CAPTURE_VALUE;
            ir_reg <= bscan_pkg::IR_RESET_VALUE; // [R1] [R18]
        end else begin
            if (tck_rise && state_reg == bscan_pkg::CAP_IR) begin
                ir_shift_reg <= bscan_pkg::IR_CAPTURE_VALUE; // [R24]
            end else if (tck_rise && state_reg == bscan_pkg::SH_IR) begin
                ir_shift_reg <= {tdi_now, ir_shift_reg[bscan_pkg::IR_WIDTH-1:1]}; // [R6]
            end
            if (upd_ir_fall) begin
                ir_reg <= ir_shift_reg; // [R23]
            end
        end
    end

    // Decode; upper nine bits ignored, anything unlisted is bypass
    assign cmd = ir_reg[bscan_pkg::CMD_WIDTH-1:0]; // [R4]
    assign sel_ext = cmd == bscan_pkg::EXTEST_INSTR; // [R5]
    assign sel_sample = cmd == bscan_pkg::SAMPLE_INSTR; // [R5]
    assign sel_id = cmd == bscan_pkg::IDCODE_INSTR; // [R5] [R13]
    assign sel_bist = cmd == bscan_pkg::RUNBIST_INSTR; // [R14]
    assign sel_bscan = sel_ext || sel_sample;
    assign sel_bypass = !sel_bscan && !sel_id && !sel_bist; // [R21] [R22] [R25]

    // Capture values: pins see pad or core, controls see direction
    genvar g;
    generate
        for (g = 0; g < PIN_GROUPS; g++) begin : g_grp
            localparam int LO = g * PINS_PER_GROUP;
            assign chain_capture[LO +: PINS_PER_GROUP] = (sel_sample && core_oe[g])
                ? core_out[LO +: PINS_PER_GROUP] : pin_in[LO +: PINS_PER_GROUP]; // [R9] [R11]
            assign chain_capture[PINS + g] = sel_ext ? upd_reg[PINS + g] : ~core_oe[g];
            // In extest, a control cell high releases the whole group
            assign pin_oe_next[LO +: PINS_PER_GROUP] = float_reg ? '0
                : sel_ext ? {PINS_PER_GROUP{~upd_reg[PINS + g]}} // [R3] [R18]
                : {PINS_PER_GROUP{core_oe[g]}};
        end
    endgenerate
    assign pin_out_next = sel_ext ? upd_reg[PINS-1:0] : core_out; // [R9]

    // Boundary chain: controls nearest tdi, pin cells nearest tdo
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chain_reg <= '0;
            upd_reg <= '1;
        end else begin
            if (tck_rise && sel_bscan && state_reg == bscan_pkg::CAP_DR) begin
                chain_reg <= chain_capture; // [R11]
            end else if (tck_rise && sel_bscan && state_reg == bscan_pkg::SH_DR) begin
                chain_reg <= {tdi_now, chain_reg[CHAIN-1:1]}; // [R2]
            end
            if (tck_fall && sel_bscan && state_reg == bscan_pkg::UPD_DR) begin
                upd_reg <= chain_reg; // [R12]
            end
        end
    end

    // Bypass and identification paths; neither touches the core
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bypass_reg <= 1'b0;
            id_reg <= ID_CODE;
        end else if (tck_rise && state_reg == bscan_pkg::CAP_DR) begin
            bypass_reg <= 1'b0; // [R21] [R7]
            id_reg <= ID_CODE; // [R13] [R7]
        end else if (tck_rise && state_reg == bscan_pkg::SH_DR) begin
            bypass_reg <= tdi_now;
            if (sel_id) begin
                id_reg <= {tdi_now, id_reg[bscan_pkg::ID_WIDTH-1:1]};
            end
        end
    end

    // Self test: armed by the instruction, started by the first idle rise
    assign bist_start = armed_reg && !started_reg && tck_rise && state_reg == bscan_pkg::RTI;
    assign bist_done = run_reg && cnt_reg == '0;
    always_ff @(posedge clk) begin
        if (!rst_b || trst_active) begin
            result_reg <= 1'b1;
            armed_reg <= 1'b0;
            started_reg <= 1'b0;
            run_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            if (upd_ir_fall) begin
                armed_reg <= ir_shift_reg[3:0] == bscan_pkg::RUNBIST_INSTR; // [R14]
                started_reg <= 1'b0;
                if (ir_shift_reg[3:0] == bscan_pkg::RUNBIST_INSTR) begin
                    result_reg <= 1'b1; // [R14]
                end
            end else if (bist_start) begin
                started_reg <= 1'b1; // [R15]
                run_reg <= 1'b1;
                cnt_reg <= CW'(BIST_CYCLES - 1);
            end else if (bist_done) begin
                run_reg <= 1'b0;
                result_reg <= bist_fail; // [R16]
            end else if (run_reg) begin
                cnt_reg <= cnt_reg - 1'b1;
            end else if (tck_rise && sel_bist && state_reg == bscan_pkg::SH_DR) begin
                result_reg <= tdi_now;
            end
        end
    end

    // Serial output changes on the falling test clock, as the standard does
    assign dr_out = sel_bscan ? chain_reg[0] : sel_id ? id_reg[0]
        : sel_bist ? result_reg : bypass_reg;
    assign serial_out = state_reg == bscan_pkg::SH_IR ? ir_shift_reg[0] : dr_out;
    assign shifting = state_reg == bscan_pkg::SH_IR || state_reg == bscan_pkg::SH_DR;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tdo_reg <= 1'b1;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg <= serial_out;
            tdo_oe_reg <= shifting;
        end
    end

    // Pin drivers and status flags, registered every cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_out_reg <= '0;
            pin_oe_reg <= '0;
            float_reg <= 1'b0;
            test_reset_reg <= 1'b1;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            float_reg <= cmd == bscan_pkg::FLOAT_ALL_OUTPUTS_INSTR; // [R18] [R19]
            test_reset_reg <= state_reg == bscan_pkg::TLR;
        end
    end

    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign tdo = tdo_reg;
    assign tdo_oe = tdo_oe_reg;
    assign bist_run = run_reg;
    assign float_active = float_reg;
    assign test_reset = test_reset_reg;

    // Helper: consecutive test-clock rises with tms high
    logic [2:0] tms_run_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tms_run_reg <= '0;
        end else if (tck_rise) begin
            tms_run_reg <= !tms_now ? 3'h0 : tms_run_reg == 3'h7 ? 3'h7 : tms_run_reg + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_trst_reset;
        trst_active |=> state_reg == bscan_pkg::TLR;
    endproperty
    a_trst_reset: assert property (p_trst_reset) else $error("trst missed reset"); // [R1]

    property p_tms_five;
        tms_run_reg >= 3'h5 |-> state_reg == bscan_pkg::TLR;
    endproperty
    a_tms_five: assert property (p_tms_five) else $error("five tms high not reset"); // [R1]

    property p_ir_capture;
        tck_rise && state_reg == bscan_pkg::CAP_IR |=> ir_shift_reg == bscan_pkg::IR_CAPTURE_VALUE;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("bad ir capture"); // [R24]

    property p_ir_update;
        upd_ir_fall && !trst_active |=> ir_reg == $past(ir_shift_reg);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("ir not updated"); // [R23]

    property p_float_effect;
        upd_ir_fall && !trst_active && ir_shift_reg[3:0] == bscan_pkg::FLOAT_ALL_OUTPUTS_INSTR
            |=> ##1 float_reg ##1 pin_oe_reg == '0;
    endproperty
    a_float_effect: assert property (p_float_effect) else $error("float late"); // [R19]

    property p_float_oe;
        float_reg |=> pin_oe_reg == '0;
    endproperty
    a_float_oe: assert property (p_float_oe) else $error("pin driven under float"); // [R18]

    property p_extest_drive;
        sel_ext && !float_reg |=> pin_out_reg == $past(upd_reg[PINS-1:0]);
    endproperty
    a_extest_drive: assert property (p_extest_drive) else $error("extest value wrong"); // [R9]

    property p_bypass_zero;
        tck_rise && state_reg == bscan_pkg::CAP_DR && sel_bypass |=> !bypass_reg;
    endproperty
    a_bypass_zero: assert property (p_bypass_zero) else $error("bypass not cleared"); // [R21]

    property p_bist_preset;
        upd_ir_fall && !trst_active && ir_shift_reg[3:0] == bscan_pkg::RUNBIST_INSTR
            |=> result_reg && armed_reg;
    endproperty
    a_bist_preset: assert property (p_bist_preset) else $error("result not preset"); // [R14]

    property p_bist_length;
        $rose(run_reg) && !trst_active |-> ##218 run_reg ##1 !run_reg;
    endproperty
    a_bist_length: assert property (p_bist_length) else $error("self test length"); // [R16]

    property p_bist_start;
        bist_start && !trst_active |=> run_reg;
    endproperty
    a_bist_start: assert property (p_bist_start) else $error("self test not started"); // [R15]

    c_bist_done: cover property ($fell(run_reg) && !result_reg);
    c_float_on: cover property ($rose(float_reg));
    c_extest_out: cover property (sel_ext && pin_oe_reg != '0);
    c_id_shift: cover property (sel_id && tdo_oe_reg);
endmodule

// ### testbench/tap_tester.sv
// Purpose: board tester model driving the serial test port
// Assumes: test clock period of 8 bench clocks, 80 ns, idling low between frames
// Notes: every pin change lands by non-blocking assignment just after a bench edge
`timescale 1ns/1ps
module tap_tester (
    input wire logic clk, // Bench clock
    input wire logic tdo, // Serial data from the device
    output bscan_pkg::tap_pins_type pins // Test port pins
);
    // Pins start in the pattern the device expects at power-up
    initial pins = bscan_pkg::PINS_RESET;

    // One test clock period; data stays put 4 clocks either side of the rise
    task automatic tick(input logic m, input logic d, output logic q);
        pins.tms <= m;
        pins.tdi <= d;
        repeat (4) @(posedge clk);
        pins.tck <= 1'b1;
        repeat (4) @(posedge clk);
        q = tdo; // Still the bit shifted at this rise, it stands until the next fall
        pins.tck <= 1'b0;
    endtask

    // Stay in Run-Test/Idle; self test starts at the first rise here, then runs on clk alone until done
    task automatic idle(input int n);
        logic q;
        repeat (n) tick(1'b0, 1'b0, q);
    endtask

    // Five high selects force the controller home from any state
    task automatic to_reset();
        logic q;
        repeat (5) tick(1'b1, 1'b1, q);
    endtask

    // Idle, one scan of n bits, back to idle
    task automatic scan(input logic ir, input logic [63:0] din, input int n,
                        output logic [63:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, 1'b0, q);
        if (ir) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        // Least significant bit goes out first
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask

    // Test reset pin held long enough to pass through the pin synchronisers
    task automatic pulse_trst();
        pins.trst_b <= 1'b0;
        repeat (6) @(posedge clk);
        pins.trst_b <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ### testbench/tb.sv
// Purpose: self-checking bench for the boundary-scan test logic
// Assumes: default pin geometry of 4 groups by 4 pins, full self-test length
// Notes: expectations are built from the command codes and chain order
`timescale 1ns/1ps
module tb;
    logic clk;
    logic rst_b;
    bscan_pkg::tap_pins_type pins;
    logic [15:0] core_out, pin_in, pin_out, pin_oe;
    logic [3:0] core_oe;
    logic bist_fail, tdo, tdo_oe, bist_run, float_active, test_reset;
    logic [63:0] dout;
    int err_total = 0;
    int checks = 0;
    int run_cnt = 0;
    int oe_cnt = 0;

    boundary_scan_tap uut (.clk(clk), .rst_b(rst_b), .tck(pins.tck), .tms(pins.tms),
        .tdi(pins.tdi), .trst_b(pins.trst_b), .core_out(core_out), .core_oe(core_oe),
        .pin_in(pin_in), .bist_fail(bist_fail), .pin_out(pin_out), .pin_oe(pin_oe),
        .tdo(tdo), .tdo_oe(tdo_oe), .bist_run(bist_run), .float_active(float_active),
        .test_reset(test_reset));
    tap_tester tester (.clk(clk), .tdo(tdo), .pins(pins));

    // Core clock never stops, self test depends on it
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cycles of self-test activity
    always @(posedge clk) if (bist_run === 1'b1) run_cnt <= run_cnt + 1;

    // Cycles with the serial output enabled; one test clock is eight bench clocks
    always @(posedge clk) if (tdo_oe === 1'b1) oe_cnt <= oe_cnt + 1;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] spread(input logic [3:0] g);
        for (int i = 0; i < 16; i++) spread[i] = g[i / 4];
    endfunction

    task automatic t_idcode();
        check("test_reset", 32'(test_reset), 32'h1);
        core_out <= 16'hC3A5;
        tester.idle(1);
        oe_cnt = 0;
        tester.scan(1'b0, 64'h0, 32, dout);
        check("idcode", dout[31:0], bscan_pkg::ID_CODE_DEFAULT);
        check("shift enable", 32'(oe_cnt), 32'(bscan_pkg::ID_WIDTH * 8));
        check("core path", 32'(pin_out), 32'h0000C3A5);
        $display("t_idcode done");
    endtask

    task automatic t_bypass();
        logic [3:0] codes [5] = '{4'hF, 4'hD, 4'hE, 4'h3, 4'hC};
        foreach (codes[i]) begin
            tester.scan(1'b1, {51'h0, 9'h1FF, codes[i]}, 13, dout);
            check("ir capture", 32'(dout[12:0]), 32'h1);
            tester.scan(1'b0, 64'h5, 3, dout);
            check("bypass", 32'(dout[2:1]), 32'h1);
        end
        $display("t_bypass done");
    endtask

    task automatic t_boundary();
        logic [19:0] cap;
        core_out <= 16'hA5C3;
        core_oe <= 4'h5;
        pin_in <= 16'h3C5A;
        tester.scan(1'b1, 64'h1, 13, dout);
        tester.scan(1'b0, {44'h0, 4'h6, 16'h1234}, 20, dout);
        cap = {~4'h5, (spread(4'h5) & 16'hA5C3) | (~spread(4'h5) & 16'h3C5A)};
        check("sample cap", 32'(dout[19:0]), 32'(cap));
        check("sample oe", 32'(pin_oe), 32'(spread(4'h5)));
        tester.scan(1'b1, 64'h0, 13, dout);
        check("extest out", 32'(pin_out), 32'h1234);
        check("extest oe", 32'(pin_oe), 32'(spread(4'h9)));
        tester.scan(1'b0, {44'h0, 4'h9, 16'hFFFF}, 20, dout);
        check("extest cap", 32'(dout[19:0]), 32'h63C5A);
        check("extest out2", 32'(pin_out), 32'hFFFF);
        check("extest oe2", 32'(pin_oe), 32'(spread(4'h6)));
        // System reset after pin testing brings normal operation back
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("rst state", 32'(test_reset), 32'h1);
        check("rst core", 32'(pin_out), 32'hA5C3);
        tester.idle(1);
        $display("t_boundary done");
    endtask

    task automatic t_float();
        core_oe <= 4'hF;
        tester.scan(1'b1, 64'hB, 13, dout);
        check("float on", 32'(float_active), 32'h1);
        check("float oe", 32'(pin_oe), 32'h0);
        tester.scan(1'b1, 64'hF, 13, dout);
        check("float off", 32'(float_active), 32'h0);
        check("drive back", 32'(pin_oe), 32'hFFFF);
        tester.scan(1'b1, 64'hB, 13, dout);
        tester.pulse_trst();
        check("trst float", 32'(float_active), 32'h0);
        check("trst state", 32'(test_reset), 32'h1);
        tester.idle(1);
        tester.scan(1'b1, 64'hB, 13, dout);
        tester.to_reset();
        repeat (4) @(posedge clk);
        check("tms float", 32'(float_active), 32'h0);
        check("tms state", 32'(test_reset), 32'h1);
        tester.idle(1);
        tester.scan(1'b0, 64'h0, 32, dout);
        check("reset instr", dout[31:0], bscan_pkg::ID_CODE_DEFAULT);
        $display("t_float done");
    endtask

    task automatic t_bist(input logic fail);
        bist_fail <= fail;
        tester.scan(1'b1, 64'h7, 13, dout);
        run_cnt = 0;
        tester.idle(32);
        check("bist length", 32'(run_cnt), 32'd219);
        tester.scan(1'b0, 64'h0, 1, dout);
        check("bist result", 32'(dout[0]), 32'(fail));
        $display("t_bist done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole sequence needs about 40 us; far past that means a hang
    initial begin
        #200000;
        err_total++;
        $display("[ERR] watchdog expired");
        end_sim();
    end

    initial begin
        rst_b = 1'b0;
        core_out = 16'h0000;
        core_oe = 4'h0;
        pin_in = 16'h0000;
        bist_fail = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_idcode();
        t_bypass();
        t_boundary();
        t_float();
        t_bist(1'b0);
        t_bist(1'b1);
        end_sim();
    end
endmodule
